/* core/rhsc_pkg.sv */
/*
 * constants and carrier types for the second bus segment control registers.
 * assumes an APB master with 32-bit data and a 125 MHz clock.
 */
package rhsc_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0]  STATUS_INDEX   = 4'h3;
    localparam logic [3:0]  COMMAND_INDEX  = 4'h4;
    localparam logic [11:0] STATUS_ADDR    = {6'h00, STATUS_INDEX, 2'h0};
    localparam logic [11:0] COMMAND_ADDR   = {6'h00, COMMAND_INDEX, 2'h0};
    // status field positions
    localparam int ST_PRESENT   = 7;
    localparam int ST_SEG_RESET = 5;
    localparam int ST_UNLOCK    = 4;
    localparam int ST_QUIESCE   = 3;
    localparam int ST_MODE_CHG  = 2;
    localparam int ST_OWNER     = 1;
    localparam int ST_RH_SLOT   = 0;
    // command field positions
    localparam int CMD_ARB_EN   = 5;
    localparam int CMD_IRQ_EN   = 4;
    localparam int CMD_SWITCH   = 3;
    localparam int CMD_XFER_NOW = 2;
    localparam int CMD_LOCK     = 1;
    localparam int CMD_RST_MASK = 0;
    // reset values, command mask and sizes
    localparam logic [7:0]  COMMAND_RESET  = 8'h00;
    localparam logic [7:0]  COMMAND_RMASK  = 8'h3B;
    localparam logic [31:0] READ_IDLE      = 32'h0000_0000;
    localparam int          SYNC_STAGES    = 2;
    localparam int          PIN_COUNT      = 13;

    // pins from outside the clock domain, synchronised as one vector
    typedef struct packed {
        logic master_reset;
        logic power_good;
        logic system_enable_n;
        logic redundant_host_n;
        logic present;
        logic owner_strap;
        logic lock_preset;
        logic redundant_slot;
        logic segment_in_reset;
        logic bus_idle;
        logic handover_req;
        logic mode_change_req;
        logic fault;
    } rhsc_pins_t;

    // controls handed to the segment interface logic
    typedef struct packed {
        logic arbiter_enable;
        logic backplane_irq_enable;
        logic switchover_request;
        logic alternate_system_enable_n;
        logic backplane_reset;
        logic locked_owner_lost;
    } rhsc_ctrl_t;
endpackage

/* core/rhsc_top.sv */
/*
 * status and command register pair of the second bus segment interface,
 * reached over APB; holds owner/drone mode and drives segment controls.
 * assumes pins arrive asynchronously and the peer host keeps its own side.
 */
`timescale 1ns/1ps

module rhsc_top (
    input  wire logic                clock_i,
    input  wire logic                reset_i,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [11:0]         paddr_i,
    input  wire logic [31:0]         pwdata_i,
    input  wire logic [3:0]          pstrb_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    input  wire rhsc_pkg::rhsc_pins_t pins_i,
    output rhsc_pkg::rhsc_ctrl_t     ctrl_o,
    output logic                     segment_event_o
);
    logic [rhsc_pkg::PIN_COUNT-1:0] sync_a;
    logic [rhsc_pkg::PIN_COUNT-1:0] sync_b;
    rhsc_pkg::rhsc_pins_t           pin;
    logic       started;
    logic       owner;
    logic       unlock;
    logic       mode_chg;
    logic       quiesce_q;
    logic       mc_req_q;
    logic       alt_n;
    logic [7:0] command;
    logic       next_started;
    logic       next_owner;
    logic       next_unlock;
    logic       next_mode_chg;
    logic       next_alt_n;
    logic [7:0] next_command;
    logic       wr;
    logic       rd;
    logic       hit_st;
    logic       hit_cmd;
    logic       cmd_wr;
    logic       clear_all;
    logic       quiesce;
    logic       mc_rise;
    logic       mode_flip;
    logic [7:0] status;
    logic [31:0] next_prdata;
    logic       next_pslverr;
    logic       next_event;

    // two-stage synchroniser for every pin
    always_ff @(posedge clock_i)
    begin
        sync_a <= pins_i;
        sync_b <= sync_a;
    end
    assign pin = rhsc_pkg::rhsc_pins_t'(sync_b);

    // bus decode
    always_comb
    begin
        wr      = psel_i & penable_i & pwrite_i;
        rd      = psel_i & ~pwrite_i; // read in setup or access phase
        hit_st  = (paddr_i == rhsc_pkg::STATUS_ADDR);
        hit_cmd = (paddr_i == rhsc_pkg::COMMAND_ADDR);
        cmd_wr  = wr & hit_cmd & pstrb_i[0] & unlock;
    end

    // command register reset source: reset_i, master reset or power-good lost
    always_comb
    begin
        clear_all = reset_i | pin.master_reset | ~pin.power_good;
    end

    // status view and events
    always_comb
    begin
        quiesce   = owner ? (~command[rhsc_pkg::CMD_ARB_EN] & pin.bus_idle)
                          : pin.handover_req;
        mc_rise   = pin.mode_change_req & ~mc_req_q;
        mode_flip = started & mc_rise & ~command[rhsc_pkg::CMD_LOCK];
        status    = 8'h00;
        status[rhsc_pkg::ST_PRESENT]   = pin.present;
        status[rhsc_pkg::ST_SEG_RESET] = pin.segment_in_reset;
        status[rhsc_pkg::ST_UNLOCK]    = unlock;
        status[rhsc_pkg::ST_QUIESCE]   = quiesce;
        status[rhsc_pkg::ST_MODE_CHG]  = mode_chg;
        status[rhsc_pkg::ST_OWNER]     = owner;
        status[rhsc_pkg::ST_RH_SLOT]   = pin.redundant_slot;
    end

    // mode, unlock and mode-change flag
    always_comb
    begin
        next_started  = 1'b1;
        next_owner    = owner;
        next_unlock   = unlock;
        next_mode_chg = mode_chg;
        if (!started)
        begin
            next_owner = pin.owner_strap;
        end
        else if (mode_flip)
        begin
            next_owner = ~owner;
        end
        if (wr && hit_st && pstrb_i[0])
        begin
            next_unlock = pwdata_i[rhsc_pkg::ST_UNLOCK];
            if (pwdata_i[rhsc_pkg::ST_MODE_CHG])
            begin
                next_mode_chg = 1'b0;
            end
        end
        if (mode_flip)
        begin
            next_mode_chg = 1'b1; // set wins over clear
        end
        if (reset_i || !pin.power_good)
        begin
            next_unlock   = 1'b0;
            next_mode_chg = 1'b0;
        end
        if (reset_i)
        begin
            next_started = 1'b0;
            next_owner   = 1'b0;
        end
    end

    always_ff @(posedge clock_i)
    begin
        started  <= next_started;
        owner    <= next_owner;
        unlock   <= next_unlock;
        mode_chg <= next_mode_chg;
    end

    // command register
    always_comb
    begin
        next_command = command;
        next_alt_n   = alt_n;
        if (cmd_wr)
        begin
            if (owner)
            begin
                next_command[rhsc_pkg::CMD_ARB_EN] = pwdata_i[rhsc_pkg::CMD_ARB_EN];
                next_command[rhsc_pkg::CMD_IRQ_EN] = pwdata_i[rhsc_pkg::CMD_IRQ_EN];
            end
            if (!mode_chg)
            begin
                next_command[rhsc_pkg::CMD_SWITCH] = pwdata_i[rhsc_pkg::CMD_SWITCH];
            end
            next_command[rhsc_pkg::CMD_LOCK]     = pwdata_i[rhsc_pkg::CMD_LOCK];
            next_command[rhsc_pkg::CMD_RST_MASK] = pwdata_i[rhsc_pkg::CMD_RST_MASK];
            if (pwdata_i[rhsc_pkg::CMD_XFER_NOW])
            begin
                next_alt_n = ~owner;
            end
        end
        // a fault disables the arbiter in owner mode unless the mode is locked
        if (owner && pin.fault && !command[rhsc_pkg::CMD_LOCK])
        begin
            next_command[rhsc_pkg::CMD_ARB_EN] = 1'b0;
        end
        // entering owner mode enables the arbiter by default
        if ((!started && pin.owner_strap) || (mode_flip && !owner))
        begin
            next_command[rhsc_pkg::CMD_ARB_EN] = 1'b1;
        end
        if ((!started) || mode_flip)
        begin
            next_alt_n = (!started) ? ~pin.owner_strap : owner;
        end
        if (!started)
        begin
            next_command[rhsc_pkg::CMD_LOCK] = pin.lock_preset;
        end
        if (!next_owner)
        begin
            next_command[rhsc_pkg::CMD_ARB_EN] = 1'b0;
            next_command[rhsc_pkg::CMD_IRQ_EN] = 1'b0;
        end
        if (pin.system_enable_n)
        begin
            next_command[rhsc_pkg::CMD_ARB_EN] = 1'b0;
            next_command[rhsc_pkg::CMD_IRQ_EN] = 1'b0;
        end
        if (mode_chg || mode_flip || !pin.redundant_host_n)
        begin
            next_command[rhsc_pkg::CMD_SWITCH] = 1'b0;
        end
        next_command = next_command & rhsc_pkg::COMMAND_RMASK;
        if (clear_all)
        begin
            next_command = rhsc_pkg::COMMAND_RESET;
            next_alt_n   = 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        command <= next_command;
        alt_n   <= next_alt_n;
    end

    // read data, error and event pulse
    always_comb
    begin
        next_prdata  = rhsc_pkg::READ_IDLE;
        next_pslverr = 1'b0;
        next_event   = (quiesce & ~quiesce_q & ~owner) | mode_flip;
        if (rd && hit_st)
        begin
            next_prdata = {24'h00_0000, status};
        end
        else if (rd && hit_cmd)
        begin
            next_prdata = {24'h00_0000, command}; // transfer-now reads zero
        end
        if (psel_i && !penable_i && !(hit_st || hit_cmd))
        begin
            next_pslverr = 1'b1; // unmapped address
        end
        if (reset_i)
        begin
            next_event = 1'b0;
        end
    end

    // register answer data in setup so it is ready for the access phase
    logic [31:0] rdata_q;
    logic        err_q;
    logic        event_q;
    always_ff @(posedge clock_i)
    begin
        quiesce_q <= reset_i ? 1'b0 : quiesce;
        mc_req_q  <= reset_i ? 1'b0 : pin.mode_change_req;
        event_q   <= next_event;
        err_q     <= reset_i ? 1'b0 : (psel_i & ~penable_i ? next_pslverr : err_q);
        rdata_q   <= reset_i ? rhsc_pkg::READ_IDLE : (psel_i ? next_prdata : rdata_q);
    end

    // outputs
    always_comb
    begin
        prdata_o        = rdata_q;
        pready_o        = 1'b1;
        pslverr_o       = psel_i & penable_i & err_q;
        segment_event_o = event_q;
        ctrl_o.arbiter_enable            = command[rhsc_pkg::CMD_ARB_EN];
        ctrl_o.backplane_irq_enable      = command[rhsc_pkg::CMD_IRQ_EN] & owner;
        ctrl_o.switchover_request        = command[rhsc_pkg::CMD_SWITCH];
        ctrl_o.alternate_system_enable_n = alt_n;
        ctrl_o.backplane_reset           = owner & pin.segment_in_reset
                                         & ~command[rhsc_pkg::CMD_RST_MASK];
        ctrl_o.locked_owner_lost         = ~owner & command[rhsc_pkg::CMD_LOCK]
                                         & mc_rise;
    end
endmodule

/* tb/redundant_host_segment_control_bench.sv */
/*
 * self-checking bench for rhsc_top with the peer host model.
 * assumes no wait states are promised; waits are bounded.
 */
`timescale 1ns/1ps
module redundant_host_segment_control_bench;
    localparam logic [11:0] ST = rhsc_pkg::STATUS_ADDR;
    localparam logic [11:0] CM = rhsc_pkg::COMMAND_ADDR;
    logic                 clock_i = 1'b0;
    logic                 reset_i = 1'b1;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic                 slow = 1'b0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0;
    logic [31:0]          rd;
    logic [31:0]          prdata;
    logic                 err;
    logic                 pready;
    logic                 pslverr;
    logic                 event_o;
    logic                 mode_req;
    rhsc_pkg::rhsc_pins_t pins = 13'h0BA8; // board switch leaves lock preset off
    rhsc_pkg::rhsc_pins_t pin_w;
    rhsc_pkg::rhsc_ctrl_t ctrl;
    int                   fail_count = 0;
    int                   tests_run = 0;
    // write data, command read back, status read back
    logic [23:0] rows [6] = '{24'h202093, 24'h00009B, 24'h313193,
                              24'h222293, 24'h242093, 24'h03039B};

    initial forever #4 clock_i = ~clock_i;
    // peer drives the mode request line
    always_comb
    begin
        pin_w = pins;
        pin_w.mode_change_req = mode_req;
    end

    rhsc_top i_dut (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pins_i(pin_w),
        .ctrl_o(ctrl), .segment_event_o(event_o));
    rhsc_peer i_peer (.clock_i(clock_i), .reset_i(reset_i), .switch_i(ctrl.switchover_request),
        .slow_i(slow), .mode_req_o(mode_req));

    task chk(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    // one APB transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock_i);
        penable <= 1'b1;
        do
        begin
            @(posedge clock_i);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk(32'(n < 20), 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input logic [11:0] a, input logic [7:0] want);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h0, want});
    endtask
    task wt(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // wait for the event flag or the lost owner pulse
    task wfor(input logic lost);
        int n;
        n = 0;
        while ((lost ? ctrl.locked_owner_lost : event_o) !== 1'b1 && n < 60)
        begin
            @(posedge clock_i);
            n++;
        end
        chk(32'(n < 60), 32'h1);
    endtask
    task done(input string s);
        $display("test %s finished", s);
    endtask
    task end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        wt(8);
        reset_i <= 1'b0;
        wt(2);
        rdc(ST, 8'h83);
        rdc(CM, 8'h20);
        chk(32'(ctrl.arbiter_enable), 32'h1);
        apb(1'b1, CM, 8'h11);
        rdc(CM, 8'h20);
        apb(1'b1, ST, 8'h10);
        rdc(ST, 8'h93);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, CM, rows[i][23:16]);
            rdc(CM, rows[i][15:8]);
            rdc(ST, rows[i][7:0]);
        end
        chk(32'(ctrl.alternate_system_enable_n), 32'h0);
        done("owner table");
        @(posedge clock_i) pins.segment_in_reset <= 1'b1;
        wt(4);
        rdc(ST, 8'hBB);
        chk(32'(ctrl.backplane_reset), 32'h0);
        apb(1'b1, CM, 8'h22);
        wt(1);
        chk(32'(ctrl.backplane_reset), 32'h1);
        @(posedge clock_i) pins.fault <= 1'b1;
        wt(4);
        rdc(CM, 8'h22);
        apb(1'b0, 12'h020, 8'h00);
        chk(32'(err), 32'h1);
        @(posedge clock_i) pins.system_enable_n <= 1'b1;
        wt(4);
        rdc(CM, 8'h02);
        @(posedge clock_i) pins.system_enable_n <= 1'b0;
        done("owner controls");
        apb(1'b1, CM, 8'h08);
        wfor(1'b0);
        rdc(ST, 8'hB5);
        rdc(CM, 8'h00);
        chk(32'(ctrl.backplane_reset), 32'h0);
        apb(1'b1, CM, 8'h3C);
        wt(1);
        chk(32'(ctrl.alternate_system_enable_n), 32'h1);
        rdc(CM, 8'h00);
        apb(1'b1, ST, 8'h14);
        rdc(ST, 8'hB1);
        @(posedge clock_i) pins.handover_req <= 1'b1;
        wfor(1'b0);
        rdc(ST, 8'hB9);
        @(posedge clock_i) pins.handover_req <= 1'b0;
        slow <= 1'b1;
        apb(1'b1, CM, 8'h0A);
        wfor(1'b1);
        rdc(ST, 8'hB1);
        done("drone mode");
        @(posedge clock_i) pins.redundant_host_n <= 1'b0;
        wt(4);
        rdc(CM, 8'h02);
        @(posedge clock_i) pins.master_reset <= 1'b1;
        wt(4);
        rdc(CM, 8'h00);
        @(posedge clock_i) pins.master_reset <= 1'b0;
        pins.power_good <= 1'b0;
        wt(4);
        @(posedge clock_i) pins.power_good <= 1'b1;
        wt(4);
        rdc(ST, 8'hA1);
        done("reset sources");
        end_of_test();
    end

    // cut a hang short
    initial
    begin
        repeat (3000) @(posedge clock_i);
        fail_count++;
        end_of_test();
    end
endmodule

/* tb/rhsc_monitor.sv */
/*
 * port checker for the segment control registers.
 * assumes it is bound to rhsc_top, pins synchronised in two stages.
 */
`timescale 1ns/1ps
module rhsc_monitor (
    input wire logic                 clock_i,
    input wire logic                 reset_i,
    input wire rhsc_pkg::rhsc_pins_t pins_i,
    input wire rhsc_pkg::rhsc_ctrl_t ctrl_o,
    input wire logic                 segment_event_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    // a peer mode request and the flag it must raise
    sequence mode_req_s;
        $rose(pins_i.mode_change_req);
    endsequence
    sequence flag_s;
        ##[1:8] (segment_event_o || ctrl_o.locked_owner_lost);
    endsequence
    // pulses last one cycle
    event_pulse_a: assert property (segment_event_o |=> !segment_event_o)
        else $error("segment event longer than one cycle");
    mode_flag_a: assert property (mode_req_s |-> flag_s)
        else $error("mode request raised no flag");
    lost_pulse_a: assert property ($rose(ctrl_o.locked_owner_lost) |=> !ctrl_o.locked_owner_lost)
        else $error("lost owner pulse too long");
    // clearing sources
    system_enable_n_clear_a: assert property (pins_i.system_enable_n [*4] |=>
        !ctrl_o.arbiter_enable && !ctrl_o.backplane_irq_enable)
        else $error("arbiter or irq enable kept while system enable off");
    mreset_clear_a: assert property (pins_i.master_reset [*4] |=>
        !ctrl_o.backplane_irq_enable && !ctrl_o.switchover_request)
        else $error("command kept through master reset");
    pgood_clear_a: assert property (!pins_i.power_good [*4] |=>
        !ctrl_o.backplane_irq_enable && !ctrl_o.switchover_request)
        else $error("command kept through power loss");
    rhost_clear_a: assert property (!pins_i.redundant_host_n [*4] |=>
        !ctrl_o.switchover_request)
        else $error("switchover kept while redundant host low");
    seg_reset_a: assert property (ctrl_o.backplane_reset |->
        $past(pins_i.segment_in_reset, 2))
        else $error("backplane reset without segment reset");
endmodule

bind rhsc_top rhsc_monitor i_mon (.clock_i(clock_i), .reset_i(reset_i), .pins_i(pins_i),
    .ctrl_o(ctrl_o), .segment_event_o(segment_event_o));

/* tb/rhsc_peer.sv */
/*
 * peer host model: answers a switchover request with a mode change request.
 * assumes switch_i is the block's switchover control.
 */
`timescale 1ns/1ps
module rhsc_peer (
    input  wire logic clock_i,
    input  wire logic reset_i,
    input  wire logic switch_i,
    input  wire logic slow_i,
    output logic      mode_req_o
);
    logic [3:0] count;
    logic       prev;
    // delay, then hold the request four cycles
    always_ff @(posedge clock_i)
    begin
        prev <= switch_i;
        if (reset_i)
            count <= 4'h0;
        else if (switch_i && !prev)
            count <= slow_i ? 4'hF : 4'h5;
        else if (count != 4'h0)
            count <= count - 4'h1;
    end
    assign mode_req_o = (count != 4'h0) && (count < 4'h5);
endmodule
